// [core/asp_regs.svh]
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH

// ----------------------------------------------------------------
// Register map (2-bit word address on the plain register port)
// ----------------------------------------------------------------
`define ASP_ADDR_CTRL        2'h0
`define ASP_ADDR_DATA        2'h1
`define ASP_ADDR_MODE        2'h2

// ----------------------------------------------------------------
// serial_control_register fields
// ----------------------------------------------------------------
`define ASP_CTRL_RX_DONE     0
`define ASP_CTRL_TX_DONE     1
`define ASP_CTRL_RX_EXTRA    2
`define ASP_CTRL_TX_EXTRA    3
`define ASP_CTRL_RX_ENABLE   4
`define ASP_CTRL_OVERRUN     6
`define ASP_CTRL_RESET       8'h00

// ----------------------------------------------------------------
// serial_mode_register fields
// ----------------------------------------------------------------
`define ASP_MODE_MCE         7
`define ASP_MODE_XBE         6
`define ASP_MODE_PE          4
`define ASP_MODE_PT_HI       3
`define ASP_MODE_PT_LO       2
`define ASP_MODE_INT_EN      1
`define ASP_MODE_THRE        0
`define ASP_MODE_RESET       8'h00

// ----------------------------------------------------------------
// Parity type encodings
// ----------------------------------------------------------------
`define ASP_PAR_ODD          2'h0
`define ASP_PAR_EVEN         2'h1
`define ASP_PAR_MARK         2'h2
`define ASP_PAR_SPACE        2'h3

// ----------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------
`define ASP_FIFO_DEPTH       3
`define ASP_CLK_HZ           100000000
`define ASP_BAUD             115200
`define ASP_OVS_RATE         16
`define ASP_OVS_CYCLES       (`ASP_CLK_HZ / (`ASP_BAUD * `ASP_OVS_RATE))
`define ASP_SUB_LAST         4'hf
`define ASP_SUB_MID          4'h7
`define ASP_LAST_DATA_BIT    3'h7

`endif

// [core/asp_pkg.sv]
package asp_pkg;

  // Transmit and receive frame walkers share one state set
  typedef enum logic [2:0] {
    ASP_IDLE,
    ASP_START,
    ASP_DATA,
    ASP_EXTRA,
    ASP_STOP
  } asp_state_t;

endpackage

// [core/asp_fifo_if.sv]
`timescale 1ns/1ps
`default_nettype none

// Link between the port core and its receive store
interface asp_fifo_if;
  logic       push;
  logic [7:0] push_data;
  logic       pop;
  logic [7:0] head;
  logic [1:0] count;
  logic       full;
  logic       empty;

  modport owner (output push, output push_data, output pop,
                 input head, input count, input full, input empty);
  modport store (input push, input push_data, input pop,
                 output head, output count, output full, output empty);
endinterface

`default_nettype wire

// [core/asp_rx_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
`include "asp_regs.svh"

// Three-entry receive store; the head entry is what the data buffer shows
module asp_rx_fifo (
  input wire logic    clk,
  input wire logic    sys_rst,
  asp_fifo_if.store   fifo
);

  logic [7:0] mem [`ASP_FIFO_DEPTH];
  logic [1:0] wr_ptr;
  logic [1:0] rd_ptr;
  logic [1:0] count;

  // Pointer wrap for a depth that is not a power of two
  function automatic logic [1:0] asp_next_ptr(input logic [1:0] p);
    asp_next_ptr = (p == 2'(`ASP_FIFO_DEPTH - 1)) ? 2'h0 : p + 2'h1;
  endfunction

  logic do_push;
  logic do_pop;
  assign do_push = fifo.push && (count != 2'(`ASP_FIFO_DEPTH));
  assign do_pop  = fifo.pop && (count != 2'h0);

  // Storage array
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= fifo.push_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      count  <= 2'h0;
    end else begin
      if (do_push) begin
        wr_ptr <= asp_next_ptr(wr_ptr);
      end
      if (do_pop) begin
        rd_ptr <= asp_next_ptr(rd_ptr);
      end
      count <= count + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  assign fifo.head  = mem[rd_ptr];
  assign fifo.count = count;
  assign fifo.full  = (count == 2'(`ASP_FIFO_DEPTH));
  assign fifo.empty = (count == 2'h0);

endmodule

`default_nettype wire

// [core/asp_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "asp_regs.svh"

module asp_top (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output var  logic [7:0] rdata,
  input  wire logic       serial_rx_pin,
  output var  logic       serial_tx_pin,
  output var  logic       irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  asp_fifo_if fifo ();

  logic             multiproc_comm_enable;
  logic             extra_bit_enable;
  logic             parity_enable;
  logic [1:0]       parity_type_select;
  logic             int_enable;
  logic             rx_enable;
  logic             tx_extra_bit;
  logic             tx_done_flag;
  logic             rx_done_flag;
  logic             rx_overrun_flag;
  logic             rx_extra_seen;

  logic [7:0]       hold_data;
  logic             hold_full;
  logic             tx_holding_empty_flag;

  logic [7:0]       ovs_cnt;
  logic             ovs_tick;

  asp_pkg::asp_state_t tx_state;
  logic [7:0]       tx_shift;
  logic             tx_x;
  logic             tx_has_x;
  logic [2:0]       tx_bitn;
  logic [3:0]       tx_sub;
  logic             tx_bit_end;
  logic             tx_load;
  logic             tx_to_stop;

  logic             rx_meta;
  logic             rx_line;
  asp_pkg::asp_state_t rx_state;
  logic [7:0]       rx_shift;
  logic             rx_x;
  logic             rx_has_x;
  logic [2:0]       rx_bitn;
  logic [3:0]       rx_sub;
  logic             rx_mid;
  logic             rx_frame_end;
  logic             rx_push;
  logic             rx_lost;
  logic             rx_done_set;

  logic             wr_ctrl;
  logic             wr_data;
  logic             wr_mode;
  logic             rd_data;

  // Register port decode, used by several processes
  function automatic logic asp_hit(input logic strobe, input logic [1:0] a, input logic [1:0] target);
    asp_hit = strobe && (a == target);
  endfunction

  // Parity bit for the selected type
  function automatic logic asp_parity(input logic [7:0] d, input logic [1:0] kind);
    case (kind)
      `ASP_PAR_ODD:  asp_parity = ~(^d);
      `ASP_PAR_EVEN: asp_parity = ^d;
      `ASP_PAR_MARK: asp_parity = 1'b1;
      default:       asp_parity = 1'b0;
    endcase
  endfunction

  assign wr_ctrl = asp_hit(wr_en, addr, `ASP_ADDR_CTRL);
  assign wr_data = asp_hit(wr_en, addr, `ASP_ADDR_DATA);
  assign wr_mode = asp_hit(wr_en, addr, `ASP_ADDR_MODE);
  assign rd_data = asp_hit(rd_en, addr, `ASP_ADDR_DATA);

  // ----------------------------------------------------------------
  // Oversampling tick
  // ----------------------------------------------------------------

  // One-cycle enable at sixteen times the bit rate
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovs_cnt  <= 8'h00;
      ovs_tick <= 1'b0;
    end else if (ovs_cnt == 8'(`ASP_OVS_CYCLES - 1)) begin
      ovs_cnt  <= 8'h00;
      ovs_tick <= 1'b1;
    end else begin
      ovs_cnt  <= ovs_cnt + 8'h01;
      ovs_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Mode and control settings
  // ----------------------------------------------------------------

  // Mode bits; software is trusted to pick a legal combination
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      multiproc_comm_enable <= 1'b0;
      extra_bit_enable      <= 1'b0;
      parity_enable         <= 1'b0;
      parity_type_select    <= `ASP_PAR_ODD;
      int_enable            <= 1'b0;
    end else if (wr_mode) begin
      multiproc_comm_enable <= wdata[`ASP_MODE_MCE];
      extra_bit_enable      <= wdata[`ASP_MODE_XBE];
      parity_enable         <= wdata[`ASP_MODE_PE];
      parity_type_select    <= wdata[`ASP_MODE_PT_HI:`ASP_MODE_PT_LO];
      int_enable            <= wdata[`ASP_MODE_INT_EN];
    end
  end

  // Plain software-owned control bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_enable    <= 1'b0;
      tx_extra_bit <= 1'b0;
    end else if (wr_ctrl) begin
      rx_enable    <= wdata[`ASP_CTRL_RX_ENABLE];
      tx_extra_bit <= wdata[`ASP_CTRL_TX_EXTRA];
    end
  end

  // ----------------------------------------------------------------
  // Event flags (hardware set always beats a software clear)
  // ----------------------------------------------------------------

  // Transmit-done flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_done_flag <= 1'b0;
    end else if (tx_to_stop) begin
      tx_done_flag <= 1'b1;
    end else if (wr_ctrl) begin
      tx_done_flag <= wdata[`ASP_CTRL_TX_DONE];
    end
  end

  // Receive-done flag; a clear is ignored while bytes remain stored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_done_flag <= 1'b0;
    end else if (rx_done_set) begin
      rx_done_flag <= 1'b1;
    end else if (wr_ctrl && wdata[`ASP_CTRL_RX_DONE]) begin
      rx_done_flag <= 1'b1;
    end else if (wr_ctrl && fifo.empty) begin
      rx_done_flag <= 1'b0;
    end
  end

  // Overrun flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_overrun_flag <= 1'b0;
    end else if (rx_lost) begin
      rx_overrun_flag <= 1'b1;
    end else if (wr_ctrl) begin
      rx_overrun_flag <= wdata[`ASP_CTRL_OVERRUN];
    end
  end

  // One interrupt line for both directions, registered
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= int_enable && (tx_done_flag || rx_done_flag);
    end
  end

  // ----------------------------------------------------------------
  // Transmit holding register
  // ----------------------------------------------------------------
  assign tx_load = (tx_state == asp_pkg::ASP_IDLE) && hold_full;

  // A write in the load cycle refills the holder, so nothing is lost
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_data <= 8'h00;
      hold_full <= 1'b0;
    end else if (wr_data) begin
      hold_data <= wdata;
      hold_full <= 1'b1;
    end else if (tx_load) begin
      hold_full <= 1'b0;
    end
  end

  assign tx_holding_empty_flag = ~hold_full;

  // ----------------------------------------------------------------
  // Transmit shifter
  // ----------------------------------------------------------------
  assign tx_bit_end = ovs_tick && (tx_sub == `ASP_SUB_LAST);
  assign tx_to_stop = tx_bit_end
                      && (((tx_state == asp_pkg::ASP_DATA) && (tx_bitn == `ASP_LAST_DATA_BIT) && !tx_has_x)
                          || (tx_state == asp_pkg::ASP_EXTRA));

  // Sub-bit counter, restarted for every frame
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_sub <= 4'h0;
    end else if (tx_state == asp_pkg::ASP_IDLE) begin
      tx_sub <= 4'h0;
    end else if (ovs_tick) begin
      tx_sub <= tx_sub + 4'h1;
    end
  end

  // Frame walker; the pin is a flop so it lags the state by one clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_state      <= asp_pkg::ASP_IDLE;
      tx_shift      <= 8'h00;
      tx_x          <= 1'b0;
      tx_has_x      <= 1'b0;
      tx_bitn       <= 3'h0;
      serial_tx_pin <= 1'b1;
    end else begin
      case (tx_state)
        asp_pkg::ASP_IDLE: begin
          serial_tx_pin <= 1'b1;
          if (tx_load) begin
            tx_shift <= hold_data;
            tx_x     <= parity_enable ? asp_parity(hold_data, parity_type_select)
                                      : tx_extra_bit;
            tx_has_x <= parity_enable || extra_bit_enable;
            tx_bitn  <= 3'h0;
            tx_state <= asp_pkg::ASP_START;
          end
        end
        asp_pkg::ASP_START: begin
          serial_tx_pin <= 1'b0;
          if (tx_bit_end) begin
            tx_state <= asp_pkg::ASP_DATA;
          end
        end
        asp_pkg::ASP_DATA: begin
          serial_tx_pin <= tx_shift[tx_bitn];
          if (tx_bit_end) begin
            if (tx_bitn != `ASP_LAST_DATA_BIT) begin
              tx_bitn <= tx_bitn + 3'h1;
            end else if (tx_has_x) begin
              tx_state <= asp_pkg::ASP_EXTRA;
            end else begin
              tx_state <= asp_pkg::ASP_STOP;
            end
          end
        end
        asp_pkg::ASP_EXTRA: begin
          serial_tx_pin <= tx_x;
          if (tx_bit_end) begin
            tx_state <= asp_pkg::ASP_STOP;
          end
        end
        asp_pkg::ASP_STOP: begin
          serial_tx_pin <= 1'b1;
          if (tx_bit_end) begin
            tx_state <= asp_pkg::ASP_IDLE;
          end
        end
        default: begin
          tx_state <= asp_pkg::ASP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive pin synchroniser
  // ----------------------------------------------------------------

  // Two flops; only rx_line is looked at by the receiver
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_meta <= 1'b1;
      rx_line <= 1'b1;
    end else begin
      rx_meta <= serial_rx_pin;
      rx_line <= rx_meta;
    end
  end

  // ----------------------------------------------------------------
  // Receive shifter
  // ----------------------------------------------------------------
  assign rx_mid = ovs_tick
                  && (rx_sub == ((rx_state == asp_pkg::ASP_START) ? `ASP_SUB_MID : `ASP_SUB_LAST));
  assign rx_frame_end = rx_mid && (rx_state == asp_pkg::ASP_STOP);
  assign rx_push      = rx_frame_end && rx_line && !fifo.full;
  assign rx_lost      = rx_frame_end && rx_line && fifo.full;
  assign rx_done_set  = rx_push && (!multiproc_comm_enable || rx_x);

  // Sub-bit counter; the first wrap lands mid start bit, later ones mid bit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_sub <= 4'h0;
    end else if ((rx_state == asp_pkg::ASP_IDLE) || (rx_mid && (rx_state == asp_pkg::ASP_START))) begin
      rx_sub <= 4'h0;
    end else if (ovs_tick) begin
      rx_sub <= rx_sub + 4'h1;
    end
  end

  // Frame walker; a start edge is only honoured while receive is enabled
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_state <= asp_pkg::ASP_IDLE;
      rx_shift <= 8'h00;
      rx_x     <= 1'b0;
      rx_has_x <= 1'b0;
      rx_bitn  <= 3'h0;
    end else begin
      case (rx_state)
        asp_pkg::ASP_IDLE: begin
          if (rx_enable && !rx_line) begin
            rx_x     <= 1'b0;
            rx_has_x <= parity_enable || extra_bit_enable;
            rx_bitn  <= 3'h0;
            rx_state <= asp_pkg::ASP_START;
          end
        end
        asp_pkg::ASP_START: begin
          if (rx_mid) begin
            // A glitch shorter than half a bit is not a start bit
            rx_state <= rx_line ? asp_pkg::ASP_IDLE : asp_pkg::ASP_DATA;
          end
        end
        asp_pkg::ASP_DATA: begin
          if (rx_mid) begin
            rx_shift <= {rx_line, rx_shift[7:1]};
            rx_bitn  <= rx_bitn + 3'h1;
            if (rx_bitn == `ASP_LAST_DATA_BIT) begin
              rx_state <= rx_has_x ? asp_pkg::ASP_EXTRA : asp_pkg::ASP_STOP;
            end
          end
        end
        asp_pkg::ASP_EXTRA: begin
          if (rx_mid) begin
            rx_x     <= rx_line;
            rx_state <= asp_pkg::ASP_STOP;
          end
        end
        asp_pkg::ASP_STOP: begin
          if (rx_mid) begin
            rx_state <= asp_pkg::ASP_IDLE;
          end
        end
        default: begin
          rx_state <= asp_pkg::ASP_IDLE;
        end
      endcase
    end
  end

  // Extra bit of the last stored frame, for software address checks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_extra_seen <= 1'b0;
    end else if (rx_push) begin
      rx_extra_seen <= rx_x;
    end
  end

  // ----------------------------------------------------------------
  // Receive store
  // ----------------------------------------------------------------
  assign fifo.push      = rx_push;
  assign fifo.push_data = rx_shift;
  assign fifo.pop       = rd_data;

  asp_rx_fifo u_rx_fifo (
    .clk     (clk),
    .sys_rst (sys_rst),
    .fifo    (fifo)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------

  // Read data is valid only in the cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        `ASP_ADDR_CTRL: begin
          rdata <= {1'b0, rx_overrun_flag, 1'b0, rx_enable, tx_extra_bit,
                    rx_extra_seen, tx_done_flag, rx_done_flag};
        end
        `ASP_ADDR_DATA: begin
          rdata <= fifo.empty ? 8'h00 : fifo.head;
        end
        `ASP_ADDR_MODE: begin
          rdata <= {multiproc_comm_enable, extra_bit_enable, 1'b0, parity_enable,
                    parity_type_select, int_enable, tx_holding_empty_flag};
        end
        default: begin
          rdata <= 8'h00;
        end
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// [testbench/asp_sva.sv]
`timescale 1ns/1ps
`default_nettype none

// -------------------------------
// Port checks for the serial port
// -------------------------------
module asp_sva (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rdata,
  input wire logic       serial_rx_pin,
  input wire logic       serial_tx_pin,
  input wire logic       irq
);
  localparam int IDLE = 11 * 864;
  logic [13:0] run;
  logic [13:0] since_wr;
  logic        last_tx;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Age of the tx level; saturates so a long idle reads as a full count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run     <= '1;
      last_tx <= 1'b1;
    end else begin
      last_tx <= serial_tx_pin;
      if (serial_tx_pin != last_tx) run <= 14'h0001;
      else if (run != '1) run <= run + 14'h0001;
    end
  end

  // Cycles since the last data buffer write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) since_wr <= '1;
    else if (wr_en && addr == 2'h1) since_wr <= '0;
    else if (since_wr != '1) since_wr <= since_wr + 14'h0001;
  end

  sequence s_rd(logic [1:0] a);
    rd_en && addr == a;
  endsequence
  sequence s_idle_wr;
    wr_en && addr == 2'h1 && serial_tx_pin && run > IDLE;
  endsequence

  chk_rdata_quiet: assert property (!rd_en |=> rdata == 8'h00)
    else $error("rdata not zero outside a read");
  chk_unmapped_read: assert property (s_rd(2'h3) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_thre_clear: assert property (s_idle_wr ##1 s_rd(2'h2) |=> !rdata[0])
    else $error("holding empty flag not cleared");
  chk_tx_start: assert property (s_idle_wr |-> ##[2:60] !serial_tx_pin)
    else $error("idle write did not start a frame");
  chk_no_spurious: assert property ($fell(serial_tx_pin) && run > IDLE |-> since_wr <= 14'h003c)
    else $error("frame started without a write");
  // Start bit may lose up to one tick of phase, so the floor is fifteen ticks plus one clock
  chk_bit_width: assert property (serial_tx_pin != last_tx |-> run >= 14'h032b)
    else $error("tx level shorter than a bit");
  chk_low_bound: assert property ($rose(serial_tx_pin) |-> run <= 14'h21c0)
    else $error("tx low longer than a frame");
  chk_irq_mask: assert property (wr_en && addr == 2'h2 && !wdata[1] |=> ##1 !irq)
    else $error("irq high while disabled");
endmodule

`default_nettype wire

// [testbench/asp_node.sv]
`timescale 1ns/1ps
`default_nettype none

// ------------------------------
// Far serial node
// ------------------------------
module asp_node #(parameter int BIT = 864) (
  input  wire logic clk,
  input  wire logic from_dev,
  output var  logic to_dev
);
  logic [7:0] got_d [3];
  logic       got_x [3];
  int         got_n = 0;

  initial to_dev = 1'b1;

  task automatic hold(input logic v, input int n);
    to_dev <= v;
    repeat (n) @(posedge clk);
  endtask

  // Low start, data LSB first, extra, high stop, idle high
  task automatic send(input logic [7:0] d, input logic x, input logic stop);
    hold(1'b0, BIT);
    for (int i = 0; i < 8; i++) hold(d[i], BIT);
    hold(x, BIT);
    // Bad stop cut short so no false start follows it
    if (!stop) hold(1'b0, 600);
    hold(1'b1, 2 * BIT);
  endtask

  // Samples device frames mid-bit; frames here always carry the extra bit
  initial begin
    forever begin
      @(negedge from_dev);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT) @(posedge clk);
        if (i < 8) got_d[got_n][i] = from_dev;
        else got_x[got_n] = from_dev;
      end
      repeat (BIT) @(posedge clk);
      got_n++;
    end
  end
endmodule

`default_nettype wire

// [testbench/asp_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none

// ------------------------------
// Serial port bench
// ------------------------------
module asp_top_tb;
  typedef struct packed {
    logic [1:0] a;
    logic [7:0] e;
  } asp_row_t;
  logic       clk       = 1'b0;
  logic       sys_rst   = 1'b1;
  logic [1:0] addr      = 2'h0;
  logic [7:0] wdata     = 8'h00;
  logic       wr_en     = 1'b0;
  logic       rd_en     = 1'b0;
  logic [7:0] rdata;
  logic       serial_rx_pin;
  logic       serial_tx_pin;
  logic       irq;
  int         err_total = 0;
  int         checks    = 0;
  int         cyc       = 0;
  asp_row_t   rows [4]  = '{'{2'h0, 8'h00}, '{2'h1, 8'h00}, '{2'h2, 8'h01}, '{2'h3, 8'h00}};

  asp_top uut (.clk, .sys_rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .serial_rx_pin, .serial_tx_pin, .irq);
  asp_node node (.clk, .from_dev(serial_tx_pin), .to_dev(serial_rx_pin));

  // 100 MHz clock
  always #5 clk = ~clk;

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Strobe stays up so writes chain with no gap; rd or the caller lowers it
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    addr  <= a;
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk("rdata", rdata, e);
    @(posedge clk);
  endtask

  // Hang guard sized above the eight frames the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      err_total++;
      wrap_up();
    end
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) rd(rows[i].a, rows[i].e);
    wr(2'h3, 8'hff);
    wr(2'h2, 8'h40);
    wr(2'h0, 8'h18);
    wr(2'h1, 8'ha5);
    rd(2'h2, 8'h40);
    wr(2'h1, 8'h3c);
    rd(2'h2, 8'h40);
    wr(2'h2, 8'h56);
    wr_en <= 1'b0;
    // Four bytes into a three-deep store while both tx frames go out
    for (int i = 1; i < 5; i++) node.send(8'(i * 8'h11), 1'b0, 1'b1);
    chk("frames", 8'(node.got_n), 8'h02);
    chk("tx0", node.got_d[0], 8'ha5);
    chk("x0", {7'h00, node.got_x[0]}, 8'h01);
    chk("tx1", node.got_d[1], 8'h3c);
    chk("x1", {7'h00, node.got_x[1]}, 8'h00);
    chk("irq", {7'h00, irq}, 8'h01);
    rd(2'h0, 8'h5b);
    wr(2'h0, 8'h18);
    rd(2'h0, 8'h19);
    for (int i = 1; i < 5; i++) rd(2'h1, (i < 4) ? 8'(i * 8'h11) : 8'h00);
    wr(2'h0, 8'h18);
    rd(2'h0, 8'h18);
    chk("irq", {7'h00, irq}, 8'h00);
    node.send(8'h55, 1'b0, 1'b0);
    rd(2'h0, 8'h18);
    rd(2'h1, 8'h00);
    wr(2'h2, 8'hc2);
    wr_en <= 1'b0;
    node.send(8'h66, 1'b0, 1'b1);
    rd(2'h0, 8'h18);
    node.send(8'h77, 1'b1, 1'b1);
    rd(2'h0, 8'h1d);
    chk("irq", {7'h00, irq}, 8'h01);
    rd(2'h1, 8'h66);
    rd(2'h1, 8'h77);
    // Receiver off while an odd-parity byte goes out and a frame comes in
    wr(2'h0, 8'h08);
    wr(2'h2, 8'h12);
    wr(2'h1, 8'h07);
    wr_en <= 1'b0;
    node.send(8'h88, 1'b1, 1'b1);
    rd(2'h0, 8'h0e);
    rd(2'h1, 8'h00);
    chk("tx2", node.got_d[2], 8'h07);
    chk("x2", {7'h00, node.got_x[2]}, 8'h00);
    wrap_up();
  end
endmodule

bind asp_top asp_sva sva_i (.clk, .sys_rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .serial_rx_pin, .serial_tx_pin, .irq);

`default_nettype wire
